/* File: include/usd_pkg.sv */
// Purpose: constants and types of the user/supervisor segment decoder
// Assumes: 64-bit virtual addresses, 36-bit physical address path
// Notes: kernel segment decoding lives elsewhere
package usd_pkg;
  localparam int unsigned USD_VA_W = 64;
  localparam int unsigned USD_SPACE_ID_W = 8;
  localparam int unsigned USD_PGN_W = 28;
  localparam int unsigned USD_PFN_W = 24;
  localparam int unsigned USD_PA_W = 36;
  localparam int unsigned USD_OFS_SMALL = 12;
  localparam int unsigned USD_OFS_LARGE = 24;
  localparam int unsigned USD_PGN_SMALL_W = 28;
  localparam int unsigned USD_PGN_LARGE_W = 16;
  localparam int unsigned USD_XUSEG_BITS = 40;
  localparam int unsigned USD_PA_HI_LSB = 32;
  localparam logic [1:0] USD_PRIV_USER = 2'h2;
  localparam logic [1:0] USD_PRIV_SUPER = 2'h1;
  localparam logic [1:0] USD_PRIV_KERNEL = 2'h0;
  localparam logic [2:0] USD_SSEG_TAG = 3'h6;
  localparam logic [1:0] USD_REG_USER = 2'h0;
  localparam logic [1:0] USD_REG_SUPER = 2'h1;
  localparam logic [1:0] USD_REG_COMPAT = 2'h3;
  localparam logic [29:0] USD_CSSEG_ONES = 30'h3FFFFFFF;
  localparam logic [3:0] USD_PA_HI_ZERO = 4'h0;

  typedef enum logic [1:0] {
    USD_MODE_KERNEL = 2'b00,
    USD_MODE_SUPER = 2'b01,
    USD_MODE_USER = 2'b10
  } usd_mode_t;

  typedef enum logic [2:0] {
    USD_SEG_NONE = 3'b000,
    USD_SEG_USEG = 3'b001,
    USD_SEG_XUSEG = 3'b010,
    USD_SEG_SSEG = 3'b011,
    USD_SEG_XSSEG = 3'b100,
    USD_SEG_CSSEG = 3'b101,
    USD_SEG_KERNEL = 3'b110
  } usd_seg_t;

  typedef enum logic [1:0] {
    USD_ST_IDLE = 2'b00,
    USD_ST_WAIT = 2'b01
  } usd_state_t;
endpackage : usd_pkg

/* File: include/usd_cls_if.sv */
// Purpose: carries one reference between the decoder and its classifier
// Assumes: purely combinational path inside one clock domain
// Notes: ctl drives the request side, cls answers
`timescale 1ns/1ns
`default_nettype none
interface usd_cls_if;
  import usd_pkg::*;
  logic [USD_VA_W-1:0] vaddr;
  logic [1:0] priv;
  logic exc_lvl;
  logic err_lvl;
  logic user_ext;
  logic super_ext;
  logic large_page;
  usd_mode_t mode;
  usd_seg_t seg;
  logic addr_err;
  logic ext_refill;
  logic [USD_PGN_W-1:0] page_num;
  logic [1:0] region;
  modport ctl (output vaddr, priv, exc_lvl, err_lvl, user_ext, super_ext,
    large_page, input mode, seg, addr_err, ext_refill, page_num, region);
  modport cls (input vaddr, priv, exc_lvl, err_lvl, user_ext, super_ext,
    large_page, output mode, seg, addr_err, ext_refill, page_num, region);
endinterface : usd_cls_if
`default_nettype wire

/* File: rtl/usd_classify.sv */
// Purpose: decode mode and segment of one virtual address
// Assumes: inputs stable within the cycle
// Notes: kernel references are only tagged, not decoded
`timescale 1ns/1ns
`default_nettype none
module usd_classify (
  usd_cls_if.cls c
);
  import usd_pkg::*;

  // operating mode from privilege field and level bits
  always_comb begin
    if (c.exc_lvl || c.err_lvl || c.priv == USD_PRIV_KERNEL) begin
      c.mode = USD_MODE_KERNEL;
    end else if (c.priv == USD_PRIV_USER) begin
      c.mode = USD_MODE_USER;
    end else if (c.priv == USD_PRIV_SUPER) begin
      c.mode = USD_MODE_SUPER;
    end else begin
      c.mode = USD_MODE_KERNEL;
    end
  end

  // segment select and address check
  always_comb begin
    c.seg = USD_SEG_NONE;
    c.addr_err = 1'b0;
    c.ext_refill = 1'b0;
    c.region = USD_REG_USER;
    if (c.mode == USD_MODE_KERNEL) begin
      c.seg = USD_SEG_KERNEL;
    end else if (c.mode == USD_MODE_USER) begin
      if (!c.user_ext) begin
        c.seg = USD_SEG_USEG;
        c.addr_err = c.vaddr[31];
      end else begin
        c.seg = USD_SEG_XUSEG;
        c.ext_refill = 1'b1;
        c.addr_err = |c.vaddr[USD_VA_W-1:USD_XUSEG_BITS];
      end
    end else if (!c.super_ext) begin
      if (!c.vaddr[31]) begin
        c.seg = USD_SEG_USEG;
      end else if (c.vaddr[31:29] == USD_SSEG_TAG) begin
        c.seg = USD_SEG_SSEG;
      end else begin
        c.addr_err = 1'b1;
      end
    end else begin
      c.ext_refill = 1'b1;
      c.region = c.vaddr[63:62];
      if (c.vaddr[63:62] == USD_REG_USER
          && c.vaddr[61:USD_XUSEG_BITS] == '0) begin
        c.seg = USD_SEG_XUSEG;
      end else if (c.vaddr[63:62] == USD_REG_SUPER
          && c.vaddr[61:USD_XUSEG_BITS] == '0) begin
        c.seg = USD_SEG_XSSEG;
      end else if (c.vaddr[63:62] == USD_REG_COMPAT
          && c.vaddr[61:32] == USD_CSSEG_ONES
          && c.vaddr[31:29] == USD_SSEG_TAG) begin
        c.seg = USD_SEG_CSSEG;
      end else begin
        c.addr_err = 1'b1;
      end
    end
  end

  // page number by page size; 32-bit segments use the low word
  always_comb begin
    c.page_num = '0;
    if (c.seg == USD_SEG_USEG || c.seg == USD_SEG_SSEG
        || c.seg == USD_SEG_CSSEG) begin
      if (c.large_page) begin
        c.page_num[USD_PGN_LARGE_W-1:0] = {8'h00, c.vaddr[31:USD_OFS_LARGE]};
      end else begin
        c.page_num[19:0] = c.vaddr[31:USD_OFS_SMALL];
      end
    end else if (c.large_page) begin
      c.page_num[USD_PGN_LARGE_W-1:0] = c.vaddr[39:USD_OFS_LARGE];
    end else begin
      c.page_num = c.vaddr[39:USD_OFS_SMALL];
    end
  end
endmodule : usd_classify
`default_nettype wire

/* File: rtl/usd_decoder.sv */
// Purpose: user/supervisor segment decoder with TLB lookup and result
// Assumes: TLB answers a lookup with tlb_rsp_valid some cycles later
// Notes: one reference in flight; req_ready_q gates new requests
`timescale 1ns/1ns
`default_nettype none
module usd_decoder #(
  parameter int unsigned SPACE_ID_W = 8,
  parameter int unsigned VA_W = 64
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [usd_pkg::USD_VA_W-1:0] req_vaddr,
  input wire logic large_page,
  input wire logic [1:0] privilege_level_field,
  input wire logic exception_level_bit,
  input wire logic error_level_bit,
  input wire logic user_extend_bit,
  input wire logic supervisor_extend_bit,
  input wire logic [usd_pkg::USD_SPACE_ID_W-1:0] address_space_identifier,
  input wire logic tlb_rsp_valid,
  input wire logic tlb_hit,
  input wire logic [usd_pkg::USD_PFN_W-1:0] tlb_pfn,
  input wire logic [2:0] tlb_cache_attr,
  output logic req_ready_q,
  output logic lookup_valid_q,
  output logic [usd_pkg::USD_PGN_W-1:0] virtual_page_number_q,
  output logic [usd_pkg::USD_SPACE_ID_W-1:0] lookup_space_id_q,
  output logic [1:0] lookup_region_q,
  output logic lookup_large_q,
  output logic done_q,
  output usd_pkg::usd_mode_t mode_q,
  output usd_pkg::usd_seg_t seg_q,
  output logic addr_err_q,
  output logic tlb_miss_q,
  output logic extended_refill_vector_q,
  output logic kernel_pass_q,
  output logic [usd_pkg::USD_PA_W-1:0] paddr_q,
  output logic [2:0] cache_attr_q
);
  import usd_pkg::*;

  // elaboration check: the datapath is built for these widths only
  if (SPACE_ID_W != USD_SPACE_ID_W || VA_W != USD_VA_W) begin : g_bad_width
    $error("usd_decoder: unsupported address or identifier width");
  end

  usd_cls_if cif ();
  usd_state_t state_q;
  logic take;
  logic [USD_VA_W-1:0] vaddr_q;
  logic ext_q;
  logic [USD_PA_W-1:0] pa_next;

  // classifier sees the live request
  assign cif.vaddr = req_vaddr;
  assign cif.priv = privilege_level_field;
  assign cif.exc_lvl = exception_level_bit;
  assign cif.err_lvl = error_level_bit;
  assign cif.user_ext = user_extend_bit;
  assign cif.super_ext = supervisor_extend_bit;
  assign cif.large_page = large_page;

  usd_classify u_cls (
    .c (cif)
  );

  assign take = req_valid && req_ready_q;

  // physical address from frame number and in-page offset
  function automatic logic [USD_PA_W-1:0] usd_make_pa(
    input logic [USD_PFN_W-1:0] pfn,
    input logic [USD_VA_W-1:0] va,
    input logic big
  );
    logic [USD_PA_W-1:0] pa;
    pa = '0;
    if (big) begin
      pa = {pfn[USD_PFN_W-1:12], va[USD_OFS_LARGE-1:0]};
    end else begin
      pa = {pfn, va[USD_OFS_SMALL-1:0]};
    end
    return pa;
  endfunction : usd_make_pa

  assign pa_next = usd_make_pa(tlb_pfn, vaddr_q, lookup_large_q);

  // sequencing: idle takes a request, wait holds for the TLB answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= USD_ST_IDLE;
      req_ready_q <= 1'b0;
    end else begin
      case (state_q)
        USD_ST_IDLE: begin
          req_ready_q <= 1'b1;
          if (take && !cif.addr_err && cif.seg != USD_SEG_KERNEL) begin
            state_q <= USD_ST_WAIT;
            req_ready_q <= 1'b0;
          end else if (take) begin
            req_ready_q <= 1'b0;
          end
        end
        USD_ST_WAIT: begin
          if (tlb_rsp_valid) begin
            state_q <= USD_ST_IDLE;
          end
        end
        default: begin
          state_q <= USD_ST_IDLE;
        end
      endcase
    end
  end

  // lookup key towards the TLB, one-cycle strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lookup_valid_q <= 1'b0;
      virtual_page_number_q <= '0;
      lookup_space_id_q <= '0;
      lookup_region_q <= '0;
      lookup_large_q <= 1'b0;
      vaddr_q <= '0;
      ext_q <= 1'b0;
    end else begin
      lookup_valid_q <= 1'b0;
      if (take) begin
        lookup_valid_q <= !cif.addr_err && cif.seg != USD_SEG_KERNEL;
        virtual_page_number_q <= cif.page_num;
        lookup_space_id_q <= address_space_identifier;
        lookup_region_q <= cif.region;
        lookup_large_q <= large_page;
        vaddr_q <= req_vaddr;
        ext_q <= cif.ext_refill;
      end
    end
  end

  // mode and segment of the reference being served
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= USD_MODE_KERNEL;
      seg_q <= USD_SEG_NONE;
    end else if (take) begin
      mode_q <= cif.mode;
      seg_q <= cif.seg;
    end
  end

  // result: early for errors and kernel, on TLB answer otherwise
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      addr_err_q <= 1'b0;
      tlb_miss_q <= 1'b0;
      extended_refill_vector_q <= 1'b0;
      kernel_pass_q <= 1'b0;
      paddr_q <= '0;
      cache_attr_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (state_q == USD_ST_IDLE && take
          && (cif.addr_err || cif.seg == USD_SEG_KERNEL)) begin
        done_q <= 1'b1;
        addr_err_q <= cif.addr_err;
        tlb_miss_q <= 1'b0;
        extended_refill_vector_q <= 1'b0;
        kernel_pass_q <= !cif.addr_err;
        paddr_q <= '0;
        cache_attr_q <= '0;
      end else if (state_q == USD_ST_WAIT && tlb_rsp_valid) begin
        done_q <= 1'b1;
        kernel_pass_q <= 1'b0;
        cache_attr_q <= tlb_hit ? tlb_cache_attr : 3'h0;
        tlb_miss_q <= !tlb_hit;
        extended_refill_vector_q <= !tlb_hit && ext_q;
        // a frame with its top bits set is refused, not truncated
        addr_err_q <= tlb_hit
          && pa_next[USD_PA_W-1:USD_PA_HI_LSB] != USD_PA_HI_ZERO;
        paddr_q <= tlb_hit ? pa_next : '0;
      end
    end
  end

  // checks on the registered results of each taken reference
  sequence s_take_user32_high;
    take && cif.mode == USD_MODE_USER && !user_extend_bit && req_vaddr[31];
  endsequence

  sequence s_err_done;
    done_q && addr_err_q && !lookup_valid_q;
  endsequence

  property p_user_mode;
    @(posedge clk_sys) disable iff (!rst_b)
    take && privilege_level_field == USD_PRIV_USER
      && !exception_level_bit && !error_level_bit
      |=> mode_q == USD_MODE_USER;
  endproperty
  a_user_mode: assert property (p_user_mode)
    else $error("user mode not decoded");

  property p_super_mode;
    @(posedge clk_sys) disable iff (!rst_b)
    take && privilege_level_field == USD_PRIV_SUPER
      && !exception_level_bit && !error_level_bit
      |=> mode_q == USD_MODE_SUPER;
  endproperty
  a_super_mode: assert property (p_super_mode)
    else $error("supervisor mode not decoded");

  property p_kernel_mode;
    @(posedge clk_sys) disable iff (!rst_b)
    take && (exception_level_bit || error_level_bit
      || privilege_level_field == USD_PRIV_KERNEL)
      |=> mode_q == USD_MODE_KERNEL && done_q && !lookup_valid_q;
  endproperty
  a_kernel_mode: assert property (p_kernel_mode)
    else $error("kernel mode not decoded");

  property p_user32_err;
    @(posedge clk_sys) disable iff (!rst_b)
    s_take_user32_high |=> s_err_done;
  endproperty
  a_user32_err: assert property (p_user32_err)
    else $error("32-bit user high address not refused");

  property p_user64_err;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_USER && user_extend_bit
      && req_vaddr[63:40] != '0
      |=> s_err_done;
  endproperty
  a_user64_err: assert property (p_user64_err)
    else $error("64-bit user high address not refused");

  property p_user_seg;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_USER && !cif.addr_err
      |=> lookup_valid_q
        && seg_q == ($past(user_extend_bit) ? USD_SEG_XUSEG : USD_SEG_USEG);
  endproperty
  a_user_seg: assert property (p_user_seg)
    else $error("user segment width wrong");

  property p_space_tag;
    @(posedge clk_sys) disable iff (!rst_b)
    take ##1 lookup_valid_q
      |-> lookup_space_id_q == $past(address_space_identifier);
  endproperty
  a_space_tag: assert property (p_space_tag)
    else $error("space identifier not carried to lookup");

  property p_sseg32;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && !supervisor_extend_bit
      && req_vaddr[31:29] == USD_SSEG_TAG
      |=> lookup_valid_q && seg_q == USD_SEG_SSEG;
  endproperty
  a_sseg32: assert property (p_sseg32)
    else $error("32-bit supervisor segment not selected");

  property p_csseg;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && supervisor_extend_bit
      && req_vaddr[63:29] == 35'h7FFFFFFFE
      |=> lookup_valid_q && seg_q == USD_SEG_CSSEG;
  endproperty
  a_csseg: assert property (p_csseg)
    else $error("separate supervisor segment not selected");

  property p_pgnum_small;
    @(posedge clk_sys) disable iff (!rst_b)
    take && !large_page && cif.mode == USD_MODE_USER && user_extend_bit
      |=> virtual_page_number_q == $past(req_vaddr[39:12]);
  endproperty
  a_pgnum_small: assert property (p_pgnum_small)
    else $error("small-page page number wrong");

  property p_miss_vector;
    @(posedge clk_sys) disable iff (!rst_b)
    state_q == USD_ST_WAIT && tlb_rsp_valid && !tlb_hit
      |=> done_q && tlb_miss_q && extended_refill_vector_q == $past(ext_q);
  endproperty
  a_miss_vector: assert property (p_miss_vector)
    else $error("refill vector choice wrong");

  property p_pa_high;
    @(posedge clk_sys) disable iff (!rst_b)
    state_q == USD_ST_WAIT && tlb_rsp_valid && tlb_hit
      && tlb_pfn[23:20] != 4'h0 && !lookup_large_q
      |=> done_q && addr_err_q;
  endproperty
  a_pa_high: assert property (p_pa_high)
    else $error("physical high bits not refused");

  property p_one_flight;
    @(posedge clk_sys) disable iff (!rst_b)
    lookup_valid_q |-> !req_ready_q ##1 (!lookup_valid_q [*2]);
  endproperty
  a_one_flight: assert property (p_one_flight)
    else $error("second lookup while one in flight");

  property p_pgnum_large;
    @(posedge clk_sys) disable iff (!rst_b)
    take && large_page && cif.mode == USD_MODE_USER && user_extend_bit
      |=> virtual_page_number_q == {12'h000, $past(req_vaddr[39:24])};
  endproperty
  a_pgnum_large: assert property (p_pgnum_large)
    else $error("large-page page number wrong");

  property p_suseg32;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && !supervisor_extend_bit
      && !req_vaddr[31] |=> lookup_valid_q && seg_q == USD_SEG_USEG;
  endproperty
  a_suseg32: assert property (p_suseg32)
    else $error("32-bit supervisor user range not selected");

  property p_super32_err;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && !supervisor_extend_bit
      && req_vaddr[31] && req_vaddr[31:29] != USD_SSEG_TAG |=> s_err_done;
  endproperty
  a_super32_err: assert property (p_super32_err)
    else $error("unlisted supervisor address not refused");

  property p_xsuseg;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && supervisor_extend_bit
      && req_vaddr[63:40] == 24'h000000
      |=> lookup_valid_q && seg_q == USD_SEG_XUSEG
        && lookup_region_q == USD_REG_USER;
  endproperty
  a_xsuseg: assert property (p_xsuseg)
    else $error("64-bit supervisor user range not selected");

  property p_xsseg;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER && supervisor_extend_bit
      && req_vaddr[63:40] == 24'h400000
      |=> lookup_valid_q && seg_q == USD_SEG_XSSEG
        && lookup_region_q == USD_REG_SUPER;
  endproperty
  a_xsseg: assert property (p_xsseg)
    else $error("current supervisor segment not selected");

  property p_super_vector;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cif.mode == USD_MODE_SUPER
      |=> ext_q == $past(supervisor_extend_bit);
  endproperty
  a_super_vector: assert property (p_super_vector)
    else $error("supervisor refill vector choice wrong");
endmodule : usd_decoder
`default_nettype wire

/* File: tb/usd_tlb_model.sv */
// Purpose: behavioural lookup table that answers the decoder's lookups
// Assumes: bench sets the answer fields before the lookup pulse
// Notes: answer after 1..4 idle cycles; fields scramble outside answers
`timescale 1ns/1ns
`default_nettype none
module usd_tlb_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic lookup_valid_q,
  input wire logic cmd_hit,
  input wire logic [23:0] cmd_pfn,
  input wire logic [2:0] cmd_attr,
  input wire logic [1:0] cmd_delay,
  output logic tlb_rsp_valid,
  output logic tlb_hit,
  output logic [23:0] tlb_pfn,
  output logic [2:0] tlb_cache_attr
);
  logic busy_q;
  logic [1:0] wait_q;

  // one answer per lookup, after the commanded wait
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      wait_q <= 2'h0;
      tlb_rsp_valid <= 1'b0;
      tlb_hit <= 1'b0;
      tlb_pfn <= 24'h000000;
      tlb_cache_attr <= 3'h0;
    end else begin
      tlb_rsp_valid <= 1'b0;
      // stale answer fields never look valid
      tlb_hit <= ~tlb_hit;
      tlb_pfn <= ~tlb_pfn;
      tlb_cache_attr <= ~tlb_cache_attr;
      if (lookup_valid_q) begin
        busy_q <= 1'b1;
        wait_q <= cmd_delay;
      end else if (busy_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        tlb_rsp_valid <= 1'b1;
        tlb_hit <= cmd_hit;
        tlb_pfn <= cmd_pfn;
        tlb_cache_attr <= cmd_attr;
      end
    end
  end
endmodule : usd_tlb_model
`default_nettype wire

/* File: tb/usd_decoder_tb_top.sv */
// Purpose: self-checking bench of the segment decoder
// Assumes: one reference in flight, lookup answered by the model
// Notes: corner addresses first, then seeded random references
`timescale 1ns/1ns
`default_nettype none
`define USD_CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module usd_decoder_tb_top;
  import usd_pkg::*;
  typedef struct packed {
    usd_mode_t mode;
    usd_seg_t seg;
    logic err;
    logic map;
    logic ext;
    logic [27:0] page_num;
    logic [1:0] rgn;
  } usd_exp_t;
  logic clk_sys, rst_b, req_valid, large_page, exc_lv, err_lv;
  logic user_ext, super_ext;
  logic [63:0] req_vaddr;
  logic [1:0] priv, cmd_delay;
  logic [7:0] space_id;
  logic cmd_hit, rsp_v, hit, req_ready_q, lookup_valid_q, lookup_large_q;
  logic [23:0] cmd_pfn, pfn;
  logic [2:0] cmd_attr, attr, cache_attr_q;
  logic [27:0] virtual_page_number_q;
  logic [7:0] lookup_space_id_q;
  logic [1:0] lookup_region_q;
  logic done_q, addr_err_q, tlb_miss_q, ext_q, kernel_pass_q;
  logic [35:0] paddr_q;
  usd_mode_t mode_q;
  usd_seg_t seg_q;
  logic [31:0] seed;
  int errors, compares;

  usd_decoder uut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
    .req_vaddr(req_vaddr), .large_page(large_page),
    .privilege_level_field(priv), .exception_level_bit(exc_lv),
    .error_level_bit(err_lv), .user_extend_bit(user_ext),
    .supervisor_extend_bit(super_ext),
    .address_space_identifier(space_id),
    .tlb_rsp_valid(rsp_v), .tlb_hit(hit), .tlb_pfn(pfn),
    .tlb_cache_attr(attr), .req_ready_q(req_ready_q),
    .lookup_valid_q(lookup_valid_q),
    .virtual_page_number_q(virtual_page_number_q),
    .lookup_space_id_q(lookup_space_id_q),
    .lookup_region_q(lookup_region_q),
    .lookup_large_q(lookup_large_q), .done_q(done_q), .mode_q(mode_q),
    .seg_q(seg_q), .addr_err_q(addr_err_q), .tlb_miss_q(tlb_miss_q),
    .extended_refill_vector_q(ext_q), .kernel_pass_q(kernel_pass_q),
    .paddr_q(paddr_q), .cache_attr_q(cache_attr_q));

  usd_tlb_model tlb (.clk_sys(clk_sys), .rst_b(rst_b),
    .lookup_valid_q(lookup_valid_q), .cmd_hit(cmd_hit), .cmd_pfn(cmd_pfn),
    .cmd_attr(cmd_attr), .cmd_delay(cmd_delay), .tlb_rsp_valid(rsp_v),
    .tlb_hit(hit), .tlb_pfn(pfn), .tlb_cache_attr(attr));

  // xorshift source, seeded at 75
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected mode, segment, error and lookup key of one reference
  function automatic usd_exp_t expect_of(logic [1:0] pv, logic el, logic rl,
      logic u, logic s, logic big, logic [63:0] va);
    usd_exp_t e;
    e = '0;
    e.mode = USD_MODE_KERNEL;
    e.seg = USD_SEG_KERNEL;
    if (!el && !rl && pv == 2'h2) begin
      e.mode = USD_MODE_USER;
      e.ext = u;
      e.seg = u ? USD_SEG_XUSEG : USD_SEG_USEG;
      e.err = u ? (va[63:40] != 24'h0) : va[31];
    end else if (!el && !rl && pv == 2'h1) begin
      e.mode = USD_MODE_SUPER;
      e.ext = s;
      if (!s) begin
        e.seg = !va[31] ? USD_SEG_USEG :
          (va[31:29] == 3'h6) ? USD_SEG_SSEG : USD_SEG_NONE;
      end else begin
        e.rgn = va[63:62];
        e.seg = (va[61:40] != 22'h0) ? USD_SEG_NONE :
          (va[63:62] == 2'h0) ? USD_SEG_XUSEG :
          (va[63:62] == 2'h1) ? USD_SEG_XSSEG : USD_SEG_NONE;
        if (va[63:29] == {32'hFFFFFFFF, 3'h6}) e.seg = USD_SEG_CSSEG;
      end
      e.err = (e.seg == USD_SEG_NONE);
    end
    e.map = (e.mode != USD_MODE_KERNEL) && !e.err;
    // only the 1 TB segments carry 28 small-page or 16 large-page bits; the rest use the low word
    e.page_num = (e.seg == USD_SEG_XUSEG || e.seg == USD_SEG_XSSEG) ?
      (big ? {12'h000, va[39:24]} : va[39:12]) :
      (big ? {20'h00000, va[31:24]} : {8'h00, va[31:12]});
    return e;
  endfunction : expect_of

  // one reference; a refused second request is held while busy
  task automatic run_one(logic [1:0] pv, logic el, logic rl, logic u,
      logic s, logic big, logic [63:0] va, logic h, logic [23:0] f,
      logic [1:0] d);
    usd_exp_t e;
    int n;
    logic [31:0] r;
    e = expect_of(pv, el, rl, u, s, big, va);
    r = rnd();
    n = 0;
    while (req_ready_q !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    {req_valid, priv, exc_lv, err_lv} <= {1'b1, pv, el, rl};
    {user_ext, super_ext} <= {u, s};
    {req_vaddr, large_page, space_id} <= {va, big, r[7:0]};
    {cmd_hit, cmd_pfn, cmd_delay, cmd_attr} <= {h, f, d, r[10:8]};
    @(posedge clk_sys);
    req_vaddr <= ~va;
    #1;
    `USD_CHK(lookup_valid_q, e.map)
    n = 0;
    if (e.map) begin
      `USD_CHK(virtual_page_number_q, e.page_num)
      `USD_CHK(lookup_space_id_q, r[7:0])
      `USD_CHK(lookup_region_q, e.rgn)
      `USD_CHK(lookup_large_q, big)
      while (done_q !== 1'b1 && n < 8) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
    end
    // key, model answer and result take three edges beyond the wait
    `USD_CHK(n, e.map ? d + 3 : 0)
    `USD_CHK(done_q, 1'b1)
    `USD_CHK(mode_q, e.mode)
    `USD_CHK(kernel_pass_q, e.mode == USD_MODE_KERNEL)
    if (!e.err) `USD_CHK(seg_q, e.seg)
    if (e.map && h) begin
      `USD_CHK(paddr_q, big ? {f[23:12], va[23:0]} : {f, va[11:0]})
      `USD_CHK(cache_attr_q, r[10:8])
      `USD_CHK(addr_err_q, f[23:20] != 4'h0)
    end else begin
      `USD_CHK(addr_err_q, e.err)
    end
    `USD_CHK(tlb_miss_q, e.map && !h)
    `USD_CHK(ext_q, e.map && !h && e.ext)
    `USD_CHK(req_ready_q, 1'b0)
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask : run_one

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end

  // corner references, then random ones
  initial begin
    logic [31:0] r;
    logic [63:0] va;
    seed = 32'h0000004B;
    errors = 0;
    compares = 0;
    {rst_b, req_valid, large_page, exc_lv, err_lv, user_ext, super_ext} = '0;
    {req_vaddr, priv, space_id, cmd_hit, cmd_pfn, cmd_attr, cmd_delay} = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    run_one(2'h2, 0, 0, 0, 0, 0, 64'h7FFFFFFF, 1, 24'h012345, 0);
    run_one(2'h2, 0, 0, 0, 0, 0, 64'h80000000, 1, 24'h012345, 0);
    run_one(2'h2, 0, 0, 0, 0, 0, 64'hC0000000, 1, 24'h0ABCDE, 1);
    run_one(2'h2, 0, 0, 0, 0, 1, 64'h1234567, 0, 24'h0, 2);
    run_one(2'h2, 0, 0, 1, 0, 1, 64'hFFFFFFFFFF, 1, 24'h0FF000, 3);
    run_one(2'h2, 0, 0, 1, 0, 0, 64'h10000000000, 1, 24'h0, 0);
    run_one(2'h2, 0, 0, 1, 0, 0, 64'h12345678, 0, 24'h0, 1);
    run_one(2'h1, 0, 0, 0, 0, 0, 64'h7FFFF000, 0, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 0, 0, 64'hC0000000, 1, 24'h00FFFF, 0);
    run_one(2'h1, 0, 0, 0, 0, 1, 64'hDFFFFFFF, 0, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 0, 0, 64'hE0000000, 1, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 1, 0, 64'hFFFFFFFFFF, 0, 24'h0, 1);
    run_one(2'h1, 0, 0, 0, 1, 1, 64'h400000FFFFFFFFFF, 1, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 1, 0, 64'hFFFFFFFFC0000000, 1, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 1, 0, 64'hFFFFFFFFDFFFFFFF, 0, 24'h0, 2);
    run_one(2'h1, 0, 0, 0, 1, 0, 64'hFFFFFFFFE0000000, 1, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 1, 0, 64'h4000010000000000, 1, 24'h0, 0);
    run_one(2'h1, 0, 0, 0, 0, 0, 64'h1000, 1, 24'hF00000, 0);
    run_one(2'h0, 0, 0, 1, 1, 0, 64'h1000, 1, 24'h0, 0);
    run_one(2'h2, 1, 0, 0, 0, 0, 64'h1000, 1, 24'h0, 0);
    run_one(2'h1, 0, 1, 0, 0, 0, 64'hC0000000, 1, 24'h0, 0);
    $display("test corner references done");
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      va = {rnd(), rnd()};
      case (r[2:0])
        3'h0: va[63:31] = '0;
        3'h1: va[63:40] = '0;
        3'h2: va[63:40] = 24'h400000;
        3'h3: va[63:29] = {32'hFFFFFFFF, 3'h6};
        3'h4: va[31:29] = 3'h6;
        default: ;
      endcase
      // mostly well-formed frames, a few with high bits set
      run_one((r[4:3] == 2'h3) ? 2'h0 : r[4:3], r[5] & r[6], r[7] & r[8],
        r[9], r[10], r[11], va, r[12] | r[13],
        {(r[14] & r[15] & r[16]) ? 4'h1 : 4'h0, r[31:12]}, r[18:17]);
    end
    $display("test random references done");
    conclude();
  end
endmodule : usd_decoder_tb_top
`default_nettype wire
